// File: core/dncs_pkg.sv
// Constants, types and helpers shared by the channel-select block.
// Assumes one 25 MHz clock and an APB master with 32-bit data.
package dncs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [11:0] DNCS_IDX_CH_SEL  = 12'h0314;
	localparam logic [11:0] DNCS_IDX_IN_SEL  = 12'h0331;
	localparam logic [11:0] DNCS_IDX_CTRL    = 12'h0334;
	localparam logic [11:0] DNCS_IDX_STATUS  = 12'h0348;

	localparam logic [11:0] DNCS_ADDR_CH_SEL = {DNCS_IDX_CH_SEL[9:0], 2'b00};
	localparam logic [11:0] DNCS_ADDR_IN_SEL = {DNCS_IDX_IN_SEL[9:0], 2'b00};
	localparam logic [11:0] DNCS_ADDR_CTRL   = {DNCS_IDX_CTRL[9:0], 2'b00};
	localparam logic [11:0] DNCS_ADDR_STATUS = {DNCS_IDX_STATUS[9:0], 2'b00};

	////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int unsigned DNCS_BIT_I_SEL   = 0;
	localparam int unsigned DNCS_LSB_MODE    = 4;
	localparam int unsigned DNCS_LSB_INDEX   = 0;
	localparam logic        DNCS_RST_I_SEL   = 1'b1;
	localparam logic [7:0]  DNCS_RST_CTRL    = 8'h00;
	localparam logic [3:0]  DNCS_RST_CH_SEL  = 4'h0;
	localparam logic [3:0]  DNCS_RST_COUNT   = 4'h0;
	localparam logic        DNCS_RST_PIN_PREV = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Selection modes
	typedef enum logic [3:0] {
		DNCS_MODE_REG    = 4'h0,
		DNCS_MODE_PINS   = 4'h1,
		DNCS_MODE_EDGE_A = 4'h8,
		DNCS_MODE_EDGE_B = 4'hA
	} dncs_mode_e;

	// Oscillator control register layout
	typedef struct packed {
		logic [3:0] mode;
		logic [3:0] index;
	} dncs_ctrl_s;

	// Undefined mode codes behave like register mode
	function automatic dncs_mode_e dncs_norm_mode(input logic [3:0] raw);
		case (raw)
			4'h1:    dncs_norm_mode = DNCS_MODE_PINS;
			4'h8:    dncs_norm_mode = DNCS_MODE_EDGE_A;
			4'hA:    dncs_norm_mode = DNCS_MODE_EDGE_B;
			default: dncs_norm_mode = DNCS_MODE_REG;
		endcase
	endfunction : dncs_norm_mode

endpackage : dncs_pkg

// File: core/dncs_profile_counter.sv
// Edge-driven oscillator profile counter.
// Assumes select pins already synchronous to clk_i.
module dncs_profile_counter (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// Control
	input  wire dncs_pkg::dncs_mode_e mode_i,
	input  wire logic [3:0]        limit_i,
	// Select pins
	input  wire logic              pin_a_i,
	input  wire logic              pin_b_i,
	// Counter value
	output logic [3:0]             count_o
);

	////////////////////////////////////////////////////////////////////////////
	// Edge detection
	logic       pin_a_prev_r;
	logic       pin_b_prev_r;
	logic [3:0] count_r;
	logic [3:0] count_nxt;
	wire        rise_a = pin_a_i & ~pin_a_prev_r;
	wire        rise_b = pin_b_i & ~pin_b_prev_r;
	wire        step   = ((mode_i == dncs_pkg::DNCS_MODE_EDGE_A) & rise_a) |
	                     ((mode_i == dncs_pkg::DNCS_MODE_EDGE_B) & rise_b);
	wire        at_top = (count_r >= limit_i);

	assign count_nxt = !step  ? count_r :
	                   at_top ? dncs_pkg::DNCS_RST_COUNT :
	                            4'(count_r + 4'h1);
	assign count_o   = count_r;

	// Previous levels start high so a pin held high at reset is no edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_a_prev_r <= dncs_pkg::DNCS_RST_PIN_PREV;
			pin_b_prev_r <= dncs_pkg::DNCS_RST_PIN_PREV;
			count_r      <= dncs_pkg::DNCS_RST_COUNT;
		end else begin
			pin_a_prev_r <= pin_a_i;
			pin_b_prev_r <= pin_b_i;
			count_r      <= count_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_edge_a_steps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(mode_i == dncs_pkg::DNCS_MODE_EDGE_A) && pin_a_i && !$past(pin_a_i) && (count_r < limit_i)
		|=> count_r == 4'($past(count_r) + 4'h1))
		else $error("counter missed rising edge on pin a");
	a_edge_b_steps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(mode_i == dncs_pkg::DNCS_MODE_EDGE_B) && pin_b_i && !pin_b_prev_r && (count_r < limit_i)
		|=> count_r == 4'($past(count_r) + 4'h1))
		else $error("counter missed rising edge on pin b");
	a_count_wraps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		step && (count_r >= limit_i) |=> count_r == 4'h0)
		else $error("counter did not wrap at limit");
	a_count_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!step |=> $stable(count_r))
		else $error("counter moved without an edge");

endmodule : dncs_profile_counter

// File: core/dncs_top.sv
// Channel and oscillator profile selection for the second downconverter.
// Assumes an APB master on clk_i and select pins synchronous to clk_i.
//
// Overview of operation
// - I input bit: 0 channel A, 1 B, resets set
// - Control: mode bits 7:4, index bits 3:0, zero
// - Mode zero: profile from channel-select register field
// - Mode one: profile is 00, pin b, pin a
// - Mode 1000: count rising edges of pin a
// - Mode 1010: count rising edges of pin b
// - Edge counter wraps to zero after index value
// - Index value N is the edge counter limit, 0 to 15
module dncs_top #(
	parameter int unsigned ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Select pins
	input  wire logic              profile_pin_a_i,
	input  wire logic              profile_pin_b_i,
	// Downconverter controls
	output logic                   i_input_sel_o,
	output logic [3:0]             active_profile_o
);

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic                 i_sel_r;
	dncs_pkg::dncs_ctrl_s ctrl_r;
	logic [3:0]           ch_sel_r;
	logic [3:0]           profile_r;
	logic [3:0]           profile_nxt;
	logic [31:0]          prdata_r;
	logic [31:0]          prdata_nxt;
	logic                 err_r;
	logic [3:0]           count;

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	wire [11:0] addr      = 12'(paddr_i);
	wire        hit_ch    = (addr == dncs_pkg::DNCS_ADDR_CH_SEL);
	wire        hit_in    = (addr == dncs_pkg::DNCS_ADDR_IN_SEL);
	wire        hit_ctrl  = (addr == dncs_pkg::DNCS_ADDR_CTRL);
	wire        hit_stat  = (addr == dncs_pkg::DNCS_ADDR_STATUS);
	wire        mapped    = hit_ch | hit_in | hit_ctrl | hit_stat;
	wire        setup     = psel_i & ~penable_i;
	wire        access    = psel_i & penable_i;
	wire        wr_ok     = access & pwrite_i & ~err_r & pstrb_i[0];
	wire        wr_ch     = wr_ok & hit_ch;
	wire        wr_in     = wr_ok & hit_in;
	wire        wr_ctrl   = wr_ok & hit_ctrl;

	////////////////////////////////////////////////////////////////////////////
	// Read data, captured in the setup phase
	wire [31:0] rd_ch     = {28'h000_0000, ch_sel_r};
	wire [31:0] rd_in     = {31'h0000_0000, i_sel_r};
	wire [31:0] rd_ctrl   = {24'h00_0000, ctrl_r};
	wire [31:0] rd_stat   = {24'h00_0000, count, profile_r};

	assign prdata_nxt = hit_ch   ? rd_ch   :
	                    hit_in   ? rd_in   :
	                    hit_ctrl ? rd_ctrl :
	                    hit_stat ? rd_stat :
	                               32'h0000_0000;

	assign pready_o  = 1'b1;
	assign pslverr_o = access & err_r;
	assign prdata_o  = prdata_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_r <= 32'h0000_0000;
			err_r    <= 1'b0;
		end else if (setup) begin
			prdata_r <= pwrite_i ? 32'h0000_0000 : prdata_nxt;
			err_r    <= ~mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			i_sel_r <= dncs_pkg::DNCS_RST_I_SEL;
		end else if (wr_in) begin
			i_sel_r <= pwdata_i[dncs_pkg::DNCS_BIT_I_SEL];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= dncs_pkg::DNCS_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_r.mode  <= pwdata_i[dncs_pkg::DNCS_LSB_MODE +: 4];
			ctrl_r.index <= pwdata_i[dncs_pkg::DNCS_LSB_INDEX +: 4];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ch_sel_r <= dncs_pkg::DNCS_RST_CH_SEL;
		end else if (wr_ch) begin
			ch_sel_r <= pwdata_i[3:0];
		end
	end

	// Channel A when clear, channel B when set
	assign i_input_sel_o = i_sel_r;

	////////////////////////////////////////////////////////////////////////////
	// Profile selection
	wire dncs_pkg::dncs_mode_e mode = dncs_pkg::dncs_norm_mode(ctrl_r.mode);

	dncs_profile_counter u_counter (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.mode_i  (mode),
		.limit_i (ctrl_r.index),
		.pin_a_i (profile_pin_a_i),
		.pin_b_i (profile_pin_b_i),
		.count_o (count)
	);

	always_comb begin
		case (mode)
			dncs_pkg::DNCS_MODE_REG:    profile_nxt = ch_sel_r;
			dncs_pkg::DNCS_MODE_PINS:   profile_nxt = {2'b00, profile_pin_b_i,
			                                           profile_pin_a_i};
			dncs_pkg::DNCS_MODE_EDGE_A: profile_nxt = count;
			dncs_pkg::DNCS_MODE_EDGE_B: profile_nxt = count;
			default:                    profile_nxt = ch_sel_r;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			profile_r <= 4'h0;
		end else begin
			profile_r <= profile_nxt;
		end
	end

	// Binary value N on the bus is profile N
	assign active_profile_o = profile_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_in_sel_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		psel_i && penable_i && pwrite_i && pstrb_i[0] && hit_in
		|=> i_input_sel_o == $past(pwdata_i[0]))
		else $error("input select did not take written value");

	a_ctrl_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		psel_i && penable_i && pwrite_i && pstrb_i[0] && hit_ctrl
		|=> ctrl_r == $past(pwdata_i[7:0]))
		else $error("control register did not take written fields");

	a_mode_reg_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl_r.mode == 4'h0) && $stable(ctrl_r) && $stable(ch_sel_r)
		|=> active_profile_o == $past(ch_sel_r))
		else $error("register mode profile mismatch");

	a_mode_pin_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ctrl_r.mode == 4'h1
		|=> active_profile_o == {2'b00, $past(profile_pin_b_i), $past(profile_pin_a_i)})
		else $error("pin mode profile mismatch");

	a_edge_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl_r.mode == 4'h8) || (ctrl_r.mode == 4'hA)
		|=> active_profile_o == $past(count))
		else $error("edge mode profile not taken from counter");

	a_bad_mode_reg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!(ctrl_r.mode inside {4'h0, 4'h1, 4'h8, 4'hA})
		|=> active_profile_o == $past(ch_sel_r))
		else $error("undefined mode did not fall back to register");

	a_unmapped_error: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		psel_i && !penable_i && !mapped ##1 psel_i && penable_i
		|-> pslverr_o && pready_o)
		else $error("unmapped access did not answer with an error");

	a_read_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		psel_i && !penable_i && !pwrite_i && hit_stat
		|=> prdata_o[3:0] == $past(profile_r))
		else $error("status read does not show active profile");

endmodule : dncs_top

// File: tb/dncs_pin_model.sv
// External logic that drives the two profile select pins.
// Assumes pins change right after a rising edge of clk_i.
module dncs_pin_model (
	// Clock
	input  wire logic clk_i,
	// Select pins
	output logic      pin_a_o,
	output logic      pin_b_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		pin_a_o = 1'b0;
		pin_b_o = 1'b0;
	end

	// Static pin levels
	task set_pins(input logic a, input logic b);
		@(posedge clk_i);
		pin_a_o <= a;
		pin_b_o <= b;
	endtask : set_pins

	// One rising edge on a single pin, two cycles high, two low
	task pulse(input logic use_b);
		@(posedge clk_i);
		if (use_b) begin
			pin_b_o <= 1'b1;
		end else begin
			pin_a_o <= 1'b1;
		end
		repeat (2) @(posedge clk_i);
		pin_a_o <= 1'b0;
		pin_b_o <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : pulse

endmodule : dncs_pin_model

// File: tb/dncs_top_tb.sv
// Self-checking bench for the channel and profile select block.
// Assumes an APB slave with any wait count and the pin model on the select pins.
module dncs_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i     = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [11:0] paddr_i   = 12'h000;
	logic [31:0] pwdata_i  = 32'h0000_0000;
	logic [3:0]  pstrb_i   = 4'hF;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        pin_a;
	logic        pin_b;
	logic        i_input_sel_o;
	logic [3:0]  active_profile_o;
	logic [31:0] rd_v;
	logic        err_v;
	logic [3:0]  cnt = 4'h0;
	int          errors = 0;
	int          checks = 0;

	always #20 clk_i = ~clk_i;

	dncs_top uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.profile_pin_a_i(pin_a), .profile_pin_b_i(pin_b),
		.i_input_sel_o(i_input_sel_o), .active_profile_o(active_profile_o)
	);

	dncs_pin_model pins (.clk_i(clk_i), .pin_a_o(pin_a), .pin_b_o(pin_b));

	////////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// One APB transfer; result lands in rd_v and err_v
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Only the watchdog ends a stalled access
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd_v = prdata_o;
		err_v = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	////////////////////////////////////////////////////////////////////////////
	task t_reset;
		chk(i_input_sel_o, 1, "I select reset");
		chk(active_profile_o, 0, "profile reset");
		apb(1'b0, dncs_pkg::DNCS_ADDR_IN_SEL, 0);
		chk(rd_v, 1, "input select reg reset");
		chk(err_v, 0, "mapped read error");
		apb(1'b0, dncs_pkg::DNCS_ADDR_CTRL, 0);
		chk(rd_v, 0, "control reg reset");
	endtask : t_reset

	task t_in_sel;
		apb(1'b1, dncs_pkg::DNCS_ADDR_IN_SEL, 32'h0000_0000);
		repeat (2) @(posedge clk_i);
		chk(i_input_sel_o, 0, "channel A");
		apb(1'b1, dncs_pkg::DNCS_ADDR_IN_SEL, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		chk(i_input_sel_o, 1, "channel B");
	endtask : t_in_sel

	// Register mode, then an undefined mode code acting like it
	task t_reg_mode(input logic [3:0] mode);
		apb(1'b1, dncs_pkg::DNCS_ADDR_CTRL, {24'h0000_00, mode, 4'h5});
		apb(1'b0, dncs_pkg::DNCS_ADDR_CTRL, 0);
		chk(rd_v, {24'h0000_00, mode, 4'h5}, "control readback");
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, dncs_pkg::DNCS_ADDR_CH_SEL, i);
			repeat (2) @(posedge clk_i);
			chk(active_profile_o, i, "register profile");
		end
	endtask : t_reg_mode

	task t_pins;
		apb(1'b1, dncs_pkg::DNCS_ADDR_CTRL, 32'h0000_0010);
		for (int i = 0; i < 4; i++) begin
			pins.set_pins(i[0], i[1]);
			repeat (2) @(posedge clk_i);
			chk(active_profile_o, {2'b00, i[1], i[0]}, "pin profile");
		end
		pins.set_pins(1'b0, 1'b0);
	endtask : t_pins

	// Edge counting on one pin; the other pin must not step it
	task t_edges(input logic [3:0] mode, input logic use_b, input logic [3:0] lim);
		apb(1'b1, dncs_pkg::DNCS_ADDR_CTRL, {24'h0000_00, mode, lim});
		pins.pulse(!use_b);
		chk(active_profile_o, cnt, "other pin ignored");
		for (int k = 0; k < 5; k++) begin
			pins.pulse(use_b);
			cnt = (cnt >= lim) ? 4'h0 : cnt + 4'h1;
			chk(active_profile_o, cnt, "edge count");
		end
		apb(1'b0, dncs_pkg::DNCS_ADDR_STATUS, 0);
		chk(rd_v, {24'h00_0000, cnt, cnt}, "status counter and profile");
	endtask : t_edges

	task t_unmapped;
		apb(1'b1, 12'h004, 32'h0000_00FF);
		chk(err_v, 1, "unmapped write error");
		apb(1'b0, 12'h004, 0);
		chk(err_v, 1, "unmapped read error");
		chk(rd_v, 0, "unmapped read data");
		apb(1'b1, dncs_pkg::DNCS_ADDR_STATUS, 32'h0000_00FF);
		chk(err_v, 0, "status write error");
		apb(1'b0, dncs_pkg::DNCS_ADDR_STATUS, 0);
		chk(rd_v, {24'h00_0000, cnt, cnt}, "status write ignored");
	endtask : t_unmapped

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_in_sel();
		t_reg_mode(4'h0);
		t_reg_mode(4'h3);
		t_pins();
		t_edges(4'h8, 1'b0, 4'h2);
		t_edges(4'hA, 1'b1, 4'h3);
		t_unmapped();
		complete_run();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		complete_run();
	end

endmodule : dncs_top_tb
